// *** design/lpgtt_tagger.sv ***
// logical port group forwarding, tail tagging and fcs regeneration
//
// Operation
// RULE_01: ports form groups of one link port and at least one network port.
// RULE_02: frames from network ports to group address get six trailer bytes before fcs.
// RULE_03: originating port code sits in bits 15..13 of first trailer word.
// RULE_04: port code equals port number plus one, port 0 is 001.
// RULE_05: trailer ends with the suffix word 0x88FB.
// RULE_06: trailer sequence counter is cleared every 5 ms.
// RULE_07: host picks egress ports for its frames, sent only there.
// RULE_08: source address of host frames leaving network ports may be replaced.
// RULE_09: frame whose source equals a port address goes out that port.
// RULE_10: frames to a group address are steered to the group's link port.
// RULE_11: other traffic is not forwarded to the link port or host.
// RULE_12: group traffic is only exchanged among that group's member ports.
// RULE_13: network port joins at most one group; link ports may be shared.
// RULE_14: frame check sequence is recomputed over the lengthened frame.
// RULE_15: frames not addressed to a group address leave without trailer.
`timescale 1ns/1ps
module lpgtt_tagger #(
  parameter int SEQ_CLR_CYCLES = lpgtt_pkg::SEQ_CLR_CYCLES
) (
  input wire logic clk, // 50 MHz switch core clock
  input wire logic reset, // synchronous, active high
  input lpgtt_pkg::lpgtt_grp_t [lpgtt_pkg::NUM_GROUPS-1:0] grp_cfg, // group setup
  input wire logic [lpgtt_pkg::NUM_PORTS-1:0][47:0] port_mac, // own port addresses
  input wire logic in_valid, // ingress byte present
  output logic in_ready, // ingress byte taken
  input lpgtt_pkg::lpgtt_in_t in_beat, // ingress byte, last, port, egress pick
  output logic out_valid, // egress byte present
  input wire logic out_ready, // egress byte taken
  output logic [7:0] out_data, // egress byte
  output logic out_last, // last fcs byte
  output logic fwd_valid, // decision pulse with last byte
  output logic fwd_tagged, // frame carried a trailer
  output logic [lpgtt_pkg::NUM_PORTS-1:0] fwd_mask, // egress port set
  output logic [lpgtt_pkg::NUM_GROUPS-1:0] grp_ok, // group is well formed
  output logic cfg_conflict // network port claimed twice
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte idx of a big-endian 48-bit value
  function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [2:0] idx);
    logic [47:0] s;
    s = mac << {idx, 3'h0};
    return s[47:40];
  endfunction : mac_byte

  // one byte of reflected crc-32
  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ lpgtt_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_byte

  lpgtt_pkg::lpgtt_state_t r_reg, r_next;
  logic [lpgtt_pkg::NUM_GROUPS-1:0][lpgtt_pkg::NUM_PORTS-1:0] own;
  logic [lpgtt_pkg::NUM_GROUPS-1:0] gvalid;
  logic [lpgtt_pkg::NUM_GROUPS-1:0] net_hit;
  logic [lpgtt_pkg::NUM_GROUPS-1:0] link_hit;
  logic [lpgtt_pkg::NUM_PORTS-1:0] claimed;
  logic [lpgtt_pkg::NUM_PORTS-1:0] port_bit;
  logic conflict;
  logic is_net;
  logic is_link;

  // ----------------------------------------------------------------
  // group membership
  // ----------------------------------------------------------------
  // lower group wins a doubly claimed port so the fabric never loops
  always_comb
  begin
    claimed = '0;
    conflict = 1'b0;
    for (int g = 0; g < lpgtt_pkg::NUM_GROUPS; g++)
    begin
      own[g] = '0;
      gvalid[g] = 1'b0;
      if (grp_cfg[g].en)
      begin
        // RULE_13: exclusive network membership
        own[g] = grp_cfg[g].net & ~claimed;
        conflict = conflict | (|(grp_cfg[g].net & claimed));
        if (grp_cfg[g].link < lpgtt_pkg::PORT_W'(lpgtt_pkg::NUM_PORTS))
          own[g][grp_cfg[g].link] = 1'b0;
        claimed = claimed | own[g];
        // RULE_01: one link plus a network port
        gvalid[g] = (grp_cfg[g].link < lpgtt_pkg::PORT_W'(lpgtt_pkg::NUM_PORTS)) && (|own[g]);
      end
    end
  end

  // ingress port class; port and egress hold for a whole frame
  always_comb
  begin
    port_bit = '0;
    if (in_beat.port < lpgtt_pkg::PORT_W'(lpgtt_pkg::NUM_PORTS))
      port_bit[in_beat.port] = 1'b1;
    for (int g = 0; g < lpgtt_pkg::NUM_GROUPS; g++)
    begin
      net_hit[g] = gvalid[g] && (|(own[g] & port_bit));
      link_hit[g] = gvalid[g] && (grp_cfg[g].link == in_beat.port);
    end
    is_net = |net_hit;
    is_link = !is_net && (|link_hit);
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  always_comb
  begin
    logic load;
    logic seq_clr;
    logic [7:0] ob;
    logic [lpgtt_pkg::NUM_PORTS-1:0] fm;
    logic [47:0] trailer;
    // a new byte may load once the held one is taken
    load = !r_reg.out_valid || out_ready;
    // RULE_06: periodic sequence clear
    seq_clr = r_reg.tick >= lpgtt_pkg::TICK_W'(SEQ_CLR_CYCLES - 1);
    ob = 8'h00;
    fm = '0;
    trailer = '0;
    r_next = r_reg;
    r_next.fwd_valid = 1'b0;
    r_next.out_valid = r_reg.out_valid && !out_ready;
    r_next.tick = seq_clr ? '0 : r_reg.tick + lpgtt_pkg::TICK_W'(1);
    // RULE_03: code in the top bits, RULE_05: fixed suffix
    trailer = {r_reg.src, r_reg.seq, lpgtt_pkg::SIZE_PAD,
               r_reg.len + lpgtt_pkg::TAG_BYTES, lpgtt_pkg::TAG_SUFFIX};
    case (r_reg.st)
      lpgtt_pkg::ST_PASS:
      begin
        if (in_valid && load)
        begin
          ob = in_beat.data;
          if (r_reg.pos == '0)
          begin
            r_next.repl_on = 1'b0;
            r_next.da_hit = '1;
            r_next.sa_hit = '1;
            // RULE_08: host frames take the group address
            for (int g = lpgtt_pkg::NUM_GROUPS - 1; g >= 0; g--)
            begin
              if (is_link && link_hit[g] && grp_cfg[g].repl)
              begin
                r_next.repl_on = 1'b1;
                r_next.repl_mac = grp_cfg[g].lmac;
              end
            end
          end
          if (r_reg.pos < lpgtt_pkg::DA_END)
          begin
            for (int g = 0; g < lpgtt_pkg::NUM_GROUPS; g++)
            begin
              r_next.da_hit[g] = ((r_reg.pos == '0) || r_reg.da_hit[g]) &&
                (in_beat.data == mac_byte(grp_cfg[g].lmac, r_reg.pos[2:0]));
            end
          end
          else if (r_reg.pos < lpgtt_pkg::SA_END)
          begin
            // original source is compared, before any replacement
            for (int q = 0; q < lpgtt_pkg::NUM_PORTS; q++)
            begin
              r_next.sa_hit[q] = r_reg.sa_hit[q] && (in_beat.data ==
                mac_byte(port_mac[q], 3'(r_reg.pos - lpgtt_pkg::DA_END)));
            end
            if (r_reg.repl_on)
              ob = mac_byte(r_reg.repl_mac, 3'(r_reg.pos - lpgtt_pkg::DA_END));
          end
          if (r_reg.pos < lpgtt_pkg::SA_END)
            r_next.pos = r_reg.pos + lpgtt_pkg::POS_W'(1);
          r_next.len = r_reg.len + lpgtt_pkg::LEN_W'(1);
          r_next.out_valid = 1'b1;
          r_next.out_data = ob;
          r_next.out_last = 1'b0;
          r_next.crc = crc_byte(r_reg.crc, ob);
          if (in_beat.last)
          begin
            r_next.fwd_tagged = 1'b0;
            for (int g = 0; g < lpgtt_pkg::NUM_GROUPS; g++)
            begin
              if (is_net && net_hit[g])
              begin
                if (r_next.da_hit[g])
                begin
                  // RULE_10: group address goes to the link port
                  fm[grp_cfg[g].link] = 1'b1;
                  // RULE_02: tag network traffic to the group
                  r_next.fwd_tagged = 1'b1;
                end
                else
                begin
                  // RULE_11: link port stays out; RULE_12: members only
                  fm = own[g] & ~port_bit;
                end
              end
              else if (is_link && link_hit[g])
                fm = fm | own[g];
            end
            if (is_link)
            begin
              // RULE_09: own port address selects that port, lowest first
              // RULE_07: otherwise host egress pick within its groups
              fm = (|r_next.sa_hit) ?
                (r_next.sa_hit & (~r_next.sa_hit + lpgtt_pkg::NUM_PORTS'(1))) :
                (fm & in_beat.egress);
            end
            r_next.fwd_mask = fm;
            // RULE_04: code is port plus one
            r_next.src = in_beat.port + lpgtt_pkg::SRC_OFFSET;
            r_next.cnt = '0;
            // RULE_15: untagged frames skip the trailer
            r_next.st = r_next.fwd_tagged ? lpgtt_pkg::ST_TAIL : lpgtt_pkg::ST_FCS;
          end
        end
      end
      lpgtt_pkg::ST_TAIL:
      begin
        if (load)
        begin
          // RULE_02: trailer bytes ahead of the fcs
          ob = mac_byte(trailer, r_reg.cnt);
          r_next.out_valid = 1'b1;
          r_next.out_data = ob;
          r_next.crc = crc_byte(r_reg.crc, ob);
          r_next.cnt = r_reg.cnt + 3'h1;
          if (r_reg.cnt == lpgtt_pkg::TAG_LAST)
          begin
            r_next.cnt = '0;
            r_next.seq = r_reg.seq + lpgtt_pkg::SEQ_W'(1);
            r_next.st = lpgtt_pkg::ST_FCS;
          end
        end
      end
      default:
      begin
        if (load)
        begin
          // RULE_14: fresh fcs over every byte sent
          ob = mac_byte({~r_reg.crc, 16'h0000}, 3'h3 - r_reg.cnt);
          r_next.out_valid = 1'b1;
          r_next.out_data = ob;
          r_next.cnt = r_reg.cnt + 3'h1;
          if (r_reg.cnt == lpgtt_pkg::FCS_LAST)
          begin
            r_next.out_last = 1'b1;
            r_next.fwd_valid = 1'b1;
            r_next.cnt = '0;
            r_next.pos = '0;
            r_next.len = '0;
            r_next.crc = lpgtt_pkg::CRC_INIT;
            r_next.st = lpgtt_pkg::ST_PASS;
          end
        end
      end
    endcase
    // clear beats a same-cycle increment, keeping the sequence field clean
    if (seq_clr)
      r_next.seq = '0;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r_reg <= '0;
      r_reg.crc <= lpgtt_pkg::CRC_INIT;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign in_ready = (r_reg.st == lpgtt_pkg::ST_PASS) && (!r_reg.out_valid || out_ready);
  assign out_valid = r_reg.out_valid;
  assign out_data = r_reg.out_data;
  assign out_last = r_reg.out_last;
  assign fwd_valid = r_reg.fwd_valid;
  assign fwd_tagged = r_reg.fwd_tagged;
  assign fwd_mask = r_reg.fwd_mask;
  assign grp_ok = gvalid;
  assign cfg_conflict = conflict;
endmodule : lpgtt_tagger

// *** shared/lpgtt_pkg.sv ***
// constants, config carriers and state type for the logical port group tail tagger
package lpgtt_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 6;
  localparam int NUM_GROUPS = 4;
  localparam int PORT_W = 3;
  localparam int SEQ_W = 13;
  localparam int LEN_W = 12;
  localparam int POS_W = 4;
  localparam int TICK_W = 20;
  // ----------------------------------------------------------------
  // frame layout and trailer format
  // ----------------------------------------------------------------
  localparam logic [POS_W-1:0] DA_END = 4'h6;
  localparam logic [POS_W-1:0] SA_END = 4'hC;
  localparam logic [2:0] TAG_LAST = 3'h5;
  localparam logic [2:0] FCS_LAST = 3'h3;
  localparam logic [LEN_W-1:0] TAG_BYTES = 12'h006;
  localparam logic [15:0] TAG_SUFFIX = 16'h88FB;
  localparam int SRC_MSB = 15;
  localparam int SRC_LSB = 13;
  localparam logic [PORT_W-1:0] SRC_OFFSET = 3'h1;
  localparam logic [3:0] SIZE_PAD = 4'h0;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int SEQ_CLR_MS = 5;
  localparam int SEQ_CLR_CYCLES = SEQ_CLR_MS * CLK_KHZ;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_PASS, ST_TAIL, ST_FCS} lpgtt_st_t;
  typedef struct packed {
    logic en;
    logic repl;
    logic [PORT_W-1:0] link;
    logic [NUM_PORTS-1:0] net;
    logic [47:0] lmac;
  } lpgtt_grp_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic [PORT_W-1:0] port;
    logic [NUM_PORTS-1:0] egress;
  } lpgtt_in_t;
  typedef struct packed {
    lpgtt_st_t st;
    logic [2:0] cnt;
    logic [POS_W-1:0] pos;
    logic [LEN_W-1:0] len;
    logic [31:0] crc;
    logic [SEQ_W-1:0] seq;
    logic [TICK_W-1:0] tick;
    logic [PORT_W-1:0] src;
    logic [NUM_GROUPS-1:0] da_hit;
    logic [NUM_PORTS-1:0] sa_hit;
    logic repl_on;
    logic [47:0] repl_mac;
    logic out_valid;
    logic [7:0] out_data;
    logic out_last;
    logic fwd_valid;
    logic fwd_tagged;
    logic [NUM_PORTS-1:0] fwd_mask;
  } lpgtt_state_t;
endpackage : lpgtt_pkg

// *** tb/lpgtt_host_model.sv ***
// host side model: byte sink behind the link port, prompt or stalling
`timescale 1ns/1ps
module lpgtt_host_model (
  input logic clk, // clock
  input logic reset, // sync reset
  input logic slow, // stall every other cycle
  input logic out_valid, // byte offered
  input logic [7:0] out_data, // offered byte
  input logic out_last, // final fcs byte
  output logic out_ready // byte accepted
);
  logic [7:0] rx [$];
  int frames = 0;
  logic tog = 1'b0;
  // alternating ready forces the tagger to hold its byte
  assign out_ready = !slow || tog;
  // record accepted bytes in wire order, count whole frames
  always @(posedge clk)
  begin
    tog <= !tog && !reset;
    if (!reset && out_valid && out_ready)
    begin
      rx.push_back(out_data);
      frames <= frames + (out_last ? 1 : 0);
    end
  end
endmodule : lpgtt_host_model

// *** tb/lpgtt_tagger_assertions.sv ***
// port checker for the tail tagger, bound into every tagger instance
`timescale 1ns/1ps
module lpgtt_checker #(
  parameter int SEQ_CLR_CYCLES = lpgtt_pkg::SEQ_CLR_CYCLES
) (
  input logic clk, // clock
  input logic reset, // sync reset
  input lpgtt_pkg::lpgtt_grp_t [lpgtt_pkg::NUM_GROUPS-1:0] grp_cfg, // groups
  input logic in_valid, // ingress valid
  input logic in_ready, // ingress ready
  input lpgtt_pkg::lpgtt_in_t in_beat, // ingress beat
  input logic out_valid, // egress valid
  input logic out_ready, // egress ready
  input logic [7:0] out_data, // egress byte
  input logic out_last, // final byte
  input logic fwd_valid, // decision pulse
  input logic fwd_tagged, // trailer added
  input logic [lpgtt_pkg::NUM_PORTS-1:0] fwd_mask, // egress set
  input logic [lpgtt_pkg::NUM_GROUPS-1:0] grp_ok, // group valid
  input logic cfg_conflict // port claimed twice
);
  logic [lpgtt_pkg::NUM_GROUPS-1:0] ok_exp;
  logic [lpgtt_pkg::NUM_PORTS-1:0] seen;
  logic [lpgtt_pkg::NUM_PORTS-1:0] links;
  logic clash;
  // independent view of group validity, overlap and link ports
  always_comb
  begin
    ok_exp = '0;
    seen = '0;
    links = '0;
    clash = 1'b0;
    for (int g = 0; g < lpgtt_pkg::NUM_GROUPS; g++)
    begin
      if (grp_cfg[g].en)
      begin
        clash = clash | (|(seen & grp_cfg[g].net));
        seen = seen | grp_cfg[g].net;
        links = links | (6'h01 << grp_cfg[g].link);
        ok_exp[g] = (grp_cfg[g].link < 3'h6) && (|(grp_cfg[g].net & ~(6'h01 << grp_cfg[g].link)));
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------
  // properties
  // ----------------
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold)
    else $error("egress byte changed while stalled");
  property p_pulse;
    fwd_valid |-> out_valid && out_last ##1 !fwd_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("decision pulse not with the final byte");
  property p_tagone;
    fwd_valid && fwd_tagged |-> $onehot(fwd_mask) && (|(fwd_mask & links));
  endproperty
  a_tagone: assert property (p_tagone)
    else $error("tagged frame not steered to one link port");
  property p_nolink;
    fwd_valid && !fwd_tagged |-> !(|(fwd_mask & links));
  endproperty
  a_nolink: assert property (p_nolink)
    else $error("untagged frame sent to a link port");
  property p_conf;
    cfg_conflict == clash;
  endproperty
  a_conf: assert property (p_conf)
    else $error("overlap flag wrong");
  property p_ok;
    !cfg_conflict |-> grp_ok == ok_exp;
  endproperty
  a_ok: assert property (p_ok)
    else $error("group status wrong");
  property p_fcs;
    in_valid && in_ready && in_beat.last |-> ##[5:60] (out_valid && out_ready && out_last);
  endproperty
  a_fcs: assert property (p_fcs)
    else $error("check sequence did not follow the frame");
  property p_gap;
    in_valid && in_ready && in_beat.last |-> ##2 !in_ready [*2];
  endproperty
  a_gap: assert property (p_gap)
    else $error("ingress accepted during trailer");
  c_tag: cover property (fwd_valid && fwd_tagged);
  c_plain: cover property (fwd_valid && !fwd_tagged);
  c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
endmodule : lpgtt_checker
bind lpgtt_tagger lpgtt_checker #(.SEQ_CLR_CYCLES(SEQ_CLR_CYCLES)) u_chk (.clk(clk),
  .reset(reset), .grp_cfg(grp_cfg), .in_valid(in_valid), .in_ready(in_ready),
  .in_beat(in_beat), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_last(out_last), .fwd_valid(fwd_valid), .fwd_tagged(fwd_tagged),
  .fwd_mask(fwd_mask), .grp_ok(grp_ok), .cfg_conflict(cfg_conflict));

// *** tb/tb_lpgtt_tagger.sv ***
// self-checking bench for the logical port group tail tagger
`timescale 1ns/1ps
module tb_lpgtt_tagger;
  localparam int CLR = 400; // short sequence clear period
  localparam logic [47:0] L0 = 48'h0200_0000_00A0; // group 0 address
  localparam logic [47:0] L1 = 48'h0200_0000_00B0; // group 1 address
  localparam logic [47:0] SA = 48'h0200_0000_0011; // station address
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF; // other traffic
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic in_valid = 1'b0;
  lpgtt_pkg::lpgtt_grp_t [lpgtt_pkg::NUM_GROUPS-1:0] grp_cfg;
  logic [lpgtt_pkg::NUM_PORTS-1:0][47:0] port_mac;
  lpgtt_pkg::lpgtt_in_t in_beat;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  logic out_last;
  logic fwd_valid;
  logic fwd_tagged;
  logic [5:0] fwd_mask;
  logic [3:0] grp_ok;
  logic cfg_conflict;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] exp_q [$];
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  lpgtt_tagger #(.SEQ_CLR_CYCLES(CLR)) dut (.clk(clk), .reset(reset), .grp_cfg(grp_cfg),
    .port_mac(port_mac), .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .fwd_valid(fwd_valid), .fwd_tagged(fwd_tagged), .fwd_mask(fwd_mask), .grp_ok(grp_ok),
    .cfg_conflict(cfg_conflict));
  lpgtt_host_model host (.clk(clk), .reset(reset), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
  // ----------------
  // helpers
  // ----------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic hang;
    fails++;
    report_and_stop();
  endtask : hang
  // 14-byte frame: addresses in wire order, then two payload bytes
  function automatic logic [7:0] byte_of(input logic [47:0] da, input logic [47:0] sa, int i);
    logic [95:0] h;
    h = {da, sa};
    return i < 12 ? h[95-8*i -: 8] : 8'(i);
  endfunction : byte_of
  // reflected crc, bitwise; slow but independent of the design
  function automatic logic [31:0] crc_of(input logic [7:0] q [$]);
    logic [31:0] c;
    c = lpgtt_pkg::CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {24'h0, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ lpgtt_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc_of
  // send one frame, then judge bytes, trailer, fcs and decision
  task automatic run_frame(input logic [2:0] p, input logic [5:0] egr, input logic [47:0] da,
    input logic [47:0] sa, input logic [47:0] sa_out, input logic tag, input logic [15:0] w0,
    input logic [5:0] mask);
    logic [31:0] c;
    int n0;
    int k;
    exp_q.delete();
    for (int i = 0; i < 14; i++)
      exp_q.push_back(byte_of(da, sa_out, i));
    if (tag)
      exp_q = {exp_q, w0[15:8], w0[7:0], 8'h00, 8'h14, 8'h88, 8'hFB};
    c = crc_of(exp_q);
    exp_q = {exp_q, c[7:0], c[15:8], c[23:16], c[31:24]};
    n0 = host.frames;
    host.rx.delete();
    @(posedge clk);
    for (int i = 0; i < 14; i++)
    begin
      in_valid <= 1'b1;
      in_beat <= '{data: byte_of(da, sa, i), last: (i == 13), port: p, egress: egr};
      k = 0;
      @(negedge clk);
      while (!in_ready && k < 100)
      begin
        @(negedge clk);
        k++;
      end
      if (k == 100)
        hang();
      @(posedge clk);
    end
    in_valid <= 1'b0;
    k = 0;
    while (host.frames == n0 && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 200)
      hang();
    @(negedge clk);
    chk(16'(host.rx.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) chk(16'(host.rx[i]), 16'(exp_q[i]));
    chk(16'(fwd_mask), 16'(mask));
    chk(16'(fwd_tagged), 16'(tag));
  endtask : run_frame
  // ----------------
  // scenarios
  // ----------------
  task automatic t_cfg;
    @(negedge clk);
    chk(16'(grp_ok), 16'h0003);
    chk(16'(cfg_conflict), 16'h0000);
    @(posedge clk);
    grp_cfg[2] <= '{en: 1'b1, repl: 1'b0, link: 3'h0, net: 6'h02, lmac: L1};
    @(negedge clk);
    chk(16'(cfg_conflict), 16'h0001);
    @(posedge clk);
    grp_cfg[2] <= '0;
    grp_cfg[3] <= '{en: 1'b1, repl: 1'b0, link: 3'h3, net: 6'h08, lmac: L1};
    @(negedge clk);
    chk(16'(grp_ok), 16'h0003);
    @(posedge clk);
    grp_cfg[3] <= '0;
    $display("test cfg done");
  endtask : t_cfg
  task automatic t_tag;
    logic [2:0] pl [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
    logic [47:0] d;
    logic [5:0] m;
    for (int i = 0; i < 4; i++)
    begin
      slow = (i == 3);
      d = pl[i] < 3'h3 ? L0 : L1;
      m = pl[i] < 3'h3 ? 6'h01 : 6'h08;
      run_frame(pl[i], 6'h00, d, SA, SA, 1'b1, {pl[i] + 3'h1, 13'(i)}, m);
    end
    slow = 1'b0;
    $display("test tagged done");
  endtask : t_tag
  task automatic t_plain;
    run_frame(3'h1, 6'h00, BC, SA, SA, 1'b0, 16'h0, 6'h04);
    run_frame(3'h5, 6'h00, L0, SA, SA, 1'b0, 16'h0, 6'h10);
    $display("test plain done");
  endtask : t_plain
  task automatic t_host;
    run_frame(3'h0, 6'h00, BC, port_mac[2], L0, 1'b0, 16'h0, 6'h04);
    run_frame(3'h0, 6'h32, BC, SA, L0, 1'b0, 16'h0, 6'h02);
    run_frame(3'h3, 6'h03, BC, SA, SA, 1'b0, 16'h0, 6'h00);
    $display("test host done");
  endtask : t_host
  task automatic t_clr;
    while (cyc < CLR + 50)
      @(posedge clk);
    run_frame(3'h2, 6'h00, L0, SA, SA, 1'b1, 16'h6000, 6'h01);
    $display("test clear done");
  endtask : t_clr
  // reset, static configuration, then the scenarios
  initial
  begin
    in_beat = '0;
    grp_cfg = '0;
    grp_cfg[0] = '{en: 1'b1, repl: 1'b1, link: 3'h0, net: 6'h06, lmac: L0};
    grp_cfg[1] = '{en: 1'b1, repl: 1'b0, link: 3'h3, net: 6'h30, lmac: L1};
    for (int p = 0; p < 6; p++)
      port_mac[p] = 48'h0200_0000_0100 + 48'(p);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_cfg();
    t_tag();
    t_plain();
    t_host();
    t_clr();
    report_and_stop();
  end
endmodule : tb_lpgtt_tagger
